// [verilog/aaa_pkg.sv]
// shared constants and types for the adc accumulator and alarm block
package aaa_pkg;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned ACC_W = 20;
  localparam int unsigned COUNT_MAX = 256;
  localparam int unsigned COUNT_W = 9;
  localparam logic [ACC_W-1:0] ACC_RESET = 20'h00000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 9'h000;
  localparam logic [11:0] LOWER_RESET = 12'h000;
  localparam logic [11:0] UPPER_RESET = 12'hfff;
  // autoconversion rate field: 0 = off, 1..7 pick a divider
  localparam int unsigned AUTO_W = 3;
  localparam logic [AUTO_W-1:0] AUTO_OFF = 3'h0;
  localparam int unsigned AUTO_DIV_W = 16;
  // dither source width and lfsr seed
  localparam int unsigned DITHER_W = 2;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // reference buffer level codes
  typedef enum logic [1:0] {
    AAA_LVL_OFF,
    AAA_LVL_1V25,
    AAA_LVL_2V048,
    AAA_LVL_2V5
  } aaa_ref_level_t;
endpackage : aaa_pkg

// [verilog/aaa_autoconv.sv]
// autoconversion start generator: one-cycle start pulses at a selectable rate
module aaa_autoconv
  import aaa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [AUTO_W-1:0] i_auto_rate,
  output logic o_start
);
  logic [AUTO_DIV_W-1:0] div_r;
  logic [AUTO_DIV_W-1:0] limit;
  logic start_r;

  // rate code n sets a period of 2^(2n) clocks; code 0 stops the generator
  always_comb begin
    limit = AUTO_DIV_W'((32'h1 << (2 * i_auto_rate)) - 32'h1);
  end

  // (RQ9) free-running start divider
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_auto_rate == AUTO_OFF) begin
      div_r <= '0;
      start_r <= 1'b0;
    end else if (div_r >= limit) begin
      div_r <= '0;
      start_r <= 1'b1;
    end else begin
      div_r <= div_r + AUTO_DIV_W'(1);
      start_r <= 1'b0;
    end
  end

  assign o_start = start_r;

  // a_auto_off_quiet: no start while disabled  // (RQ9)
  a_auto_off_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_auto_rate == AUTO_OFF) |=> !o_start) else $error("start pulse while autoconversion off");
endmodule // aaa_autoconv

// [verilog/aaa_accum_alarms.sv]
// adc result accumulator, dither source, threshold alarms and reference controls
// Summary of operation
// (RQ1) a 20-bit sum adds successive 12-bit results, up to 256 samples
// (RQ2) the full flag rises once the programmed sample count has been summed
// (RQ3) one completed sum is produced per n conversions
// (RQ4) an internal dither source may be added to each sample during summing
// (RQ5) host averages by shifting the sum right once per doubling of count
// (RQ6) host gets 16-bit results from 256 dithered samples, shift four, keep low 16
// (RQ7) enabled alarms compare each new result against lower and upper thresholds
// (RQ8) host reprograms thresholds when it picks another input channel
// (RQ9) autoconversion starts conversions repeatedly; a three-bit field sets the rate
// (RQ10) reference enable turns the internal 2.5V reference on or off
// (RQ11) converter and dac reference buffers each pick 1.25, 2.048 or 2.5V
// (RQ12) host disables a buffer that an external reference drives directly
// (RQ13) after a completed sum the accumulator restarts, holding the last sum
module aaa_accum_alarms
  import aaa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_result_valid,
  input wire logic [RESULT_W-1:0] i_result,
  input wire logic [COUNT_W-1:0] i_sample_count,
  input wire logic i_dither_enable,
  input wire logic i_accum_flag_clear,
  input wire logic i_alarm_enable,
  input wire logic [RESULT_W-1:0] i_lower_threshold,
  input wire logic [RESULT_W-1:0] i_upper_threshold,
  input wire logic i_alarm_clear,
  input wire logic [AUTO_W-1:0] i_auto_rate,
  input wire logic i_int_ref_enable,
  input wire logic [1:0] i_conv_ref_level,
  input wire logic [1:0] i_dac_ref_level,
  output logic [ACC_W-1:0] o_accum_sum,
  output logic o_accum_full_flag,
  output logic o_sum_done,
  output logic o_upper_alarm_flag,
  output logic o_lower_alarm_flag,
  output logic o_conv_start,
  output logic o_int_ref_enable,
  output logic [1:0] o_conv_ref_buffer_out,
  output logic [1:0] o_dac_ref_buffer_out
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] sum_r;
  logic [COUNT_W-1:0] cnt_r;
  logic full_r;
  logic done_r;
  logic upper_r;
  logic lower_r;
  logic [15:0] lfsr_r;
  logic ref_en_r;
  aaa_ref_level_t conv_lvl_r;
  aaa_ref_level_t dac_lvl_r;
  logic [COUNT_W-1:0] target;
  logic [ACC_W-1:0] sample;
  logic [ACC_W-1:0] acc_nxt;
  logic last;

  // clamp a programmed count into 1..256
  function automatic logic [COUNT_W-1:0] clamp_count(input logic [COUNT_W-1:0] n);
    if (n == COUNT_RESET) begin
      return COUNT_W'(1);
    end else if (n > COUNT_W'(COUNT_MAX)) begin
      return COUNT_W'(COUNT_MAX);
    end else begin
      return n;
    end
  endfunction

  // (RQ4) dither adds small pseudo-random lsbs
  always_comb begin
    target = clamp_count(i_sample_count);
    sample = ACC_W'(i_result);
    if (i_dither_enable) begin
      sample = ACC_W'(i_result) + ACC_W'(lfsr_r[DITHER_W-1:0]);
    end
    last = (cnt_r + COUNT_W'(1)) >= target;
    acc_nxt = acc_r + sample;
  end

  // dither lfsr, steps on every accepted result so sums stay repeatable
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lfsr_r <= LFSR_SEED;
    end else if (i_result_valid) begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // (RQ1) accumulate and count samples; (RQ13) restart after each sum
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      acc_r <= ACC_RESET;
      cnt_r <= COUNT_RESET;
    end else if (i_result_valid) begin
      if (last) begin
        acc_r <= ACC_RESET;
        cnt_r <= COUNT_RESET;
      end else begin
        acc_r <= acc_nxt;
        cnt_r <= cnt_r + COUNT_W'(1);
      end
    end
  end

  // (RQ3) completed sum held until replaced, one done pulse per n results
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sum_r <= ACC_RESET;
      done_r <= 1'b0;
    end else begin
      done_r <= i_result_valid && last;
      if (i_result_valid && last) begin
        sum_r <= acc_nxt;
      end
    end
  end

  // (RQ2) sticky full flag; a completion in the clear cycle wins
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      full_r <= 1'b0;
    end else if (i_result_valid && last) begin
      full_r <= 1'b1;
    end else if (i_accum_flag_clear) begin
      full_r <= 1'b0;
    end
  end

  // (RQ7) threshold alarms on each new result, set beats clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      upper_r <= 1'b0;
      lower_r <= 1'b0;
    end else begin
      if (i_alarm_enable && i_result_valid && i_result > i_upper_threshold) begin
        upper_r <= 1'b1;
      end else if (i_alarm_clear) begin
        upper_r <= 1'b0;
      end
      if (i_alarm_enable && i_result_valid && i_result < i_lower_threshold) begin
        lower_r <= 1'b1;
      end else if (i_alarm_clear) begin
        lower_r <= 1'b0;
      end
    end
  end

  // (RQ10) (RQ11) registered reference controls; off code lets an external source drive the pin
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ref_en_r <= 1'b0;
      conv_lvl_r <= AAA_LVL_OFF;
      dac_lvl_r <= AAA_LVL_OFF;
    end else begin
      ref_en_r <= i_int_ref_enable;
      conv_lvl_r <= aaa_ref_level_t'(i_conv_ref_level);
      dac_lvl_r <= aaa_ref_level_t'(i_dac_ref_level);
    end
  end

  // (RQ9) autoconversion start pulses
  aaa_autoconv u_auto (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_auto_rate(i_auto_rate),
    .o_start(o_conv_start)
  );

  assign o_accum_sum = sum_r;
  assign o_accum_full_flag = full_r;
  assign o_sum_done = done_r;
  assign o_upper_alarm_flag = upper_r;
  assign o_lower_alarm_flag = lower_r;
  assign o_int_ref_enable = ref_en_r;
  assign o_conv_ref_buffer_out = conv_lvl_r;
  assign o_dac_ref_buffer_out = dac_lvl_r;

  // a_full_on_done: flag follows every completion  // (RQ2)
  a_full_on_done: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_sum_done |-> o_accum_full_flag) else $error("full flag missing after completed sum");

  // a_sum_done_value: sum is previous acc plus sample  // (RQ1)
  a_sum_done_value: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_result_valid && last) |=> (o_accum_sum == $past(acc_nxt))) else $error("completed sum wrong");

  // a_count_bound: counter stays below 256  // (RQ3)
  a_count_bound: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cnt_r < COUNT_W'(COUNT_MAX)) else $error("sample counter overran");

  // a_restart_clear: accumulation restarts at zero  // (RQ13)
  a_restart_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_sum_done |-> (acc_r == ACC_RESET && cnt_r == COUNT_RESET)) else $error("accumulator not restarted");

  // a_sum_holds: held sum changes only on completion  // (RQ13)
  a_sum_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_sum_done |-> $stable(o_accum_sum)) else $error("held sum changed without completion");

  // a_upper_alarm_set: crossing raises upper flag  // (RQ7)
  a_upper_alarm_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_alarm_enable && i_result_valid && i_result > i_upper_threshold) |=> o_upper_alarm_flag)
    else $error("upper alarm not raised");

  // a_lower_alarm_set: crossing raises lower flag  // (RQ7)
  a_lower_alarm_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_alarm_enable && i_result_valid && i_result < i_lower_threshold) |=> o_lower_alarm_flag)
    else $error("lower alarm not raised");

  // a_ref_follows_enable: reference output is on the cycle after its enable is set  // (RQ10)
  a_ref_follows_enable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_int_ref_enable |=> o_int_ref_enable) else $error("internal reference not enabled");
endmodule // aaa_accum_alarms

// [bench/aaa_host_model.sv]
// host-side model: turns completed sums into averages as software would
module aaa_host_model
  import aaa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sum_done,
  input wire logic [ACC_W-1:0] i_accum_sum,
  input wire logic [COUNT_W-1:0] i_sample_count,
  output logic [ACC_W-1:0] o_average,
  output logic [15:0] o_res16
);
  timeunit 1ns;
  timeprecision 1ns;

  // doublings of the count; a count that is no power of two rounds up
  function automatic int doublings(input logic [COUNT_W-1:0] n);
    int s;
    s = 0;
    while ((32'h1 << s) < 32'(n)) begin
      s++;
    end
    return s;
  endfunction

  always @(posedge i_clock) begin
    if (i_sum_done) begin
      o_average <= i_accum_sum >> doublings(i_sample_count);
      o_res16 <= 16'(i_accum_sum >> 4); // low 16 after shift of four
    end
  end
endmodule // aaa_host_model

// [bench/tb.sv]
// self-checking bench for the accumulator, alarms, autoconversion and reference controls
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb
  import aaa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_result_valid = 1'b0, i_dither_enable = 1'b0;
  logic i_accum_flag_clear = 1'b0, i_alarm_enable = 1'b0, i_alarm_clear = 1'b0, i_int_ref_enable = 1'b0;
  logic [RESULT_W-1:0] i_result = 12'h000, i_lower_threshold = 12'h000, i_upper_threshold = 12'hfff;
  logic [COUNT_W-1:0] i_sample_count = 9'h001;
  logic [AUTO_W-1:0] i_auto_rate = 3'h0;
  logic [1:0] i_conv_ref_level = 2'h0, i_dac_ref_level = 2'h0;
  logic [ACC_W-1:0] o_accum_sum, avg, exp_sum, lo, hi;
  logic [15:0] res16;
  logic o_accum_full_flag, o_sum_done, o_upper_alarm_flag, o_lower_alarm_flag, o_conv_start, o_int_ref_enable;
  logic [1:0] o_conv_ref_buffer_out, o_dac_ref_buffer_out;
  integer seed = 32'hbbccba54;
  int miscompares = 0, check_count = 0, n, pulses;
  int cnt[5] = '{1, 4, 256, 3, 0};
  int shf[5] = '{0, 2, 8, 2, 0}; // averaging shifts, one per doubling of the count

  aaa_accum_alarms u_aaa_accum_alarms (.i_clock, .i_rst_n, .i_result_valid, .i_result, .i_sample_count,
    .i_dither_enable, .i_accum_flag_clear, .i_alarm_enable, .i_lower_threshold, .i_upper_threshold,
    .i_alarm_clear, .i_auto_rate, .i_int_ref_enable, .i_conv_ref_level, .i_dac_ref_level, .o_accum_sum,
    .o_accum_full_flag, .o_sum_done, .o_upper_alarm_flag, .o_lower_alarm_flag, .o_conv_start,
    .o_int_ref_enable, .o_conv_ref_buffer_out, .o_dac_ref_buffer_out);
  aaa_host_model u_aaa_host_model (.i_clock(i_clock), .i_sum_done(o_sum_done), .i_accum_sum(o_accum_sum),
    .i_sample_count(i_sample_count), .o_average(avg), .o_res16(res16));

  // free-running 10 MHz clock
  always #50 i_clock = ~i_clock;

  // inputs move a fixed 10 ns after the rising edge
  task step;
    @(posedge i_clock);
    #10;
  endtask

  // plain sum of k equal samples, no dither
  function automatic logic [ACC_W-1:0] flat_sum(input int k, input logic [RESULT_W-1:0] r);
    return ACC_W'(k) * ACC_W'(r);
  endfunction

  task end_of_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // run needs about 2000 cycles; allow ten times that
  initial begin
    #(20000 * 100);
    miscompares++;
    end_of_test;
  end

  initial begin
    repeat (2) step;
    i_rst_n = 1'b1;
    `CHK(o_accum_sum, 20'h00000)
    `CHK(o_accum_full_flag, 1'b0)
    // back-to-back sums over boundary counts; a count of 0 is taken as 1
    foreach (cnt[k]) begin
      i_sample_count = 9'(cnt[k]);
      exp_sum = 20'h00000;
      for (n = 0; n < (cnt[k] == 0 ? 1 : cnt[k]); n++) begin
        `CHK(o_sum_done, 1'b0)
        i_result = 12'($random(seed));
        exp_sum += 20'(i_result);
        i_result_valid = 1'b1;
        step;
      end
      i_result_valid = 1'b0;
      `CHK(o_sum_done, 1'b1)
      `CHK(o_accum_sum, exp_sum)
      `CHK(o_accum_full_flag, 1'b1)
      step;
      `CHK(o_accum_sum, exp_sum)
      `CHK(avg, exp_sum >> shf[k])
      i_accum_flag_clear = 1'b1;
      step;
      i_accum_flag_clear = 1'b0;
      step;
      `CHK(o_accum_full_flag, 1'b0)
    end
    // dithered sums of one level lie between the plain sum and three extra lsbs a sample
    i_dither_enable = 1'b1;
    i_result = 12'($random(seed)) & 12'h7ff; // small enough that 256 dithered samples cannot wrap
    for (n = 4; n <= 256; n = n * 64) begin
      i_sample_count = 9'(n);
      lo = flat_sum(n, i_result);
      hi = lo + flat_sum(n, 12'h003);
      i_result_valid = 1'b1;
      repeat (n) step;
      i_result_valid = 1'b0;
      `CHK(o_sum_done, 1'b1)
      `CHK(o_accum_sum >= lo && o_accum_sum <= hi, 1'b1)
      // a nonzero lfsr never shows 256 zero dither steps in a row
      if (n == 256) `CHK(o_accum_sum != lo, 1'b1)
      step;
      `CHK(res16 >= 16'(lo >> 4) && res16 <= 16'(hi >> 4), 1'b1)
    end
    i_dither_enable = 1'b0;
    i_sample_count = 9'h100;
    // thresholds reprogrammed as on a channel change, strict edges probed
    i_lower_threshold = 12'h300 + 12'($random(seed) & 32'hff);
    i_upper_threshold = i_lower_threshold + 12'h400;
    for (n = 0; n < 5; n++) begin
      i_alarm_enable = (n != 4);
      i_result = (n == 0) ? i_lower_threshold - 12'h001 : (n == 1) ? i_lower_threshold :
        (n == 2) ? i_upper_threshold : (n == 3) ? i_upper_threshold + 12'h001 : 12'h000;
      i_result_valid = 1'b1;
      step;
      i_result_valid = 1'b0;
      step;
      `CHK(o_lower_alarm_flag, n == 0)
      `CHK(o_upper_alarm_flag, n == 3)
      i_alarm_clear = 1'b1;
      step;
      i_alarm_clear = 1'b0;
    end
    // rate codes up to 4 give four starts 4^n apart; slower codes must stay silent early on
    for (n = 1; n < 8; n++) begin
      i_auto_rate = 3'(n);
      pulses = 0;
      repeat (4 * (4 ** (n > 4 ? 1 : n)) + 2) begin
        step;
        pulses += int'(o_conv_start);
      end
      `CHK(pulses, (n <= 4) ? 4 : 0)
      i_auto_rate = 3'h0;
      repeat (2) step;
    end
    // random reference selections
    repeat (6) begin
      {i_int_ref_enable, i_conv_ref_level, i_dac_ref_level} = 5'($random(seed));
      step;
      `CHK(o_int_ref_enable, i_int_ref_enable)
      `CHK(o_conv_ref_buffer_out, i_conv_ref_level)
      `CHK(o_dac_ref_buffer_out, i_dac_ref_level)
    end
    // external reference applied: buffer switched off
    i_conv_ref_level = 2'h0;
    step;
    `CHK(o_conv_ref_buffer_out, AAA_LVL_OFF)
    end_of_test;
  end
endmodule // tb
